/* pkg/pll_ctl_params.svh */
// Field positions, reset values, source codes and timing counts of the loop control block.
`ifndef PLL_CTL_PARAMS_SVH
`define PLL_CTL_PARAMS_SVH
`define PRE_LSB 0
`define PRE_MSB 4
`define POST_LSB 6
`define POST_MSB 7
`define RCDIV_LSB 8
`define RCDIV_MSB 10
`define FBD_LSB 0
`define FBD_MSB 8
`define OSC_SWITCH_REQUEST_BIT_BIT 0
`define OSC_LOCK_BIT 5
`define OSC_REQUESTED_SOURCE_FIELD_LSB 8
`define OSC_REQUESTED_SOURCE_FIELD_MSB 10
`define OSC_CURRENT_SOURCE_FIELD_LSB 12
`define OSC_CURRENT_SOURCE_FIELD_MSB 14
`define PRE_RST 5'h00
`define POST_RST 2'h1
`define FBD_RST 9'h030
`define RCDIV_RST 3'h0
`define SRC_RC 3'h0
`define SRC_RC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define OST_CYCLES 1024
`define CLK_PERIOD_NS 4
`define LOCK_TIME_NS 20000
`define LOCK_CYCLES_DEF ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* pkg/pll_ctl_pkg.sv */
// Types and shared decode functions of the loop control block.
package pll_ctl_pkg;
  `include "pll_ctl_params.svh"

  typedef enum logic [1:0] {ST_BOOT, ST_WAIT_OSC, ST_LOCK, ST_RUN} pll_state_t;

  typedef logic [2:0] src_code_t;

  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == `SRC_RC_PLL) || (src == `SRC_PRI_PLL);
  endfunction

  function automatic logic is_primary(input logic [2:0] src);
    is_primary = (src == `SRC_PRI) || (src == `SRC_PRI_PLL);
  endfunction

  function automatic logic [8:0] rc_div_ratio(input logic [2:0] code);
    if (code == 3'h7) begin
      rc_div_ratio = 9'h100;
    end else begin
      rc_div_ratio = 9'(9'h001 << code);
    end
  endfunction
endpackage

/* logic/startup_counter.sv */
// Ten-bit oscillator start-up counter that releases the clock after a full count.
`timescale 1ns/10ps
`include "pll_ctl_params.svh"
module startup_counter (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Control
  input logic start,
  input logic osc_cycle,
  // Status
  output logic done
);
  logic [9:0] cnt_r;
  logic run_r;
  logic done_r;
  wire last_w = run_r && osc_cycle && (cnt_r == 10'(`OST_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 10'h000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r <= 10'h000;
      run_r <= 1'b1;
      done_r <= 1'b0;
    end else if (run_r && osc_cycle) begin
      cnt_r <= 10'(cnt_r + 10'h001);
      run_r <= !last_w;
      done_r <= last_w;
    end
  end

  assign done = done_r;
endmodule

/* logic/rc_postscaler.sv */
// Divider for the internal RC clock that yields one tick per divided period.
`timescale 1ns/10ps
module rc_postscaler
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Divider setting
  input logic [2:0] div_code,
  // Divided output
  output logic tick
);
  logic [8:0] cnt_r;
  logic tick_r;
  wire [8:0] ratio_w = rc_div_ratio(div_code);
  wire wrap_w = (cnt_r >= 9'(ratio_w - 9'h001));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= wrap_w ? 9'h000 : 9'(cnt_r + 9'h001);
      tick_r <= wrap_w;
    end
  end

  assign tick = tick_r;
endmodule

/* logic/pll_divider_and_lock_control.sv */
// Divider fields, source switching and lock status of the frequency-multiplying loop.
`timescale 1ns/10ps
`include "pll_ctl_params.svh"
module pll_divider_and_lock_control
  import pll_ctl_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CYCLES_DEF
)(
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Configuration straps
  input logic [2:0] reset_source_select,
  input logic primary_is_crystal,
  // Primary oscillator cycle strobe
  input logic primary_cycle,
  // Clock divisor register write
  input logic clock_divisor_register_we,
  input logic [15:0] clock_divisor_register_wdata,
  // Feedback divisor register write
  input logic feedback_divisor_register_we,
  input logic [15:0] feedback_divisor_register_wdata,
  // Oscillator control register byte writes
  input logic osc_ctrl_high_we,
  input logic [7:0] osc_ctrl_high_wdata,
  input logic osc_ctrl_low_we,
  input logic [7:0] osc_ctrl_low_wdata,
  // Register read back
  output logic [15:0] clock_divisor_register_rdata,
  output logic [15:0] feedback_divisor_register_rdata,
  output logic [15:0] oscillator_control_register_rdata,
  // Loop settings and status
  output logic [5:0] prescale_ratio,
  output logic [9:0] feedback_ratio,
  output logic [3:0] postscale_ratio,
  output logic [8:0] sysclk_denominator,
  output logic [8:0] rc_divisor,
  output logic loop_in_from_primary,
  output logic loop_in_tick,
  output logic loop_selected,
  output logic lock_status,
  output logic instr_clk_en
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic [4:0] input_prescale_field_r;
  logic [1:0] output_postscale_field_r;
  logic [8:0] feedback_ratio_field_r;
  logic [2:0] rc_postscale_field_r;
  logic [2:0] requested_source_field_r;
  logic [2:0] current_source_field_r;
  logic [2:0] current_source_field_nxt;
  logic switch_request_bit_r;
  logic switch_request_bit_nxt;
  logic lock_r;
  logic lock_nxt;
  pll_state_t state_r;
  pll_state_t state_nxt;
  logic [19:0] lock_cnt_r;
  logic [19:0] lock_cnt_nxt;
  logic ost_start;
  logic icyc_r;
  logic rc_tick;
  logic ost_done;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Decodes of the software writes and of the switch in progress.
  wire busy_w = (state_r != ST_RUN);
  wire [2:0] dest_w = requested_source_field_r;
  wire div_changed_w = clock_divisor_register_we || feedback_divisor_register_we;
  wire rc_changed_w = clock_divisor_register_we &&
                      (clock_divisor_register_wdata[`RCDIV_MSB:`RCDIV_LSB] != rc_postscale_field_r);
  wire relock_w = uses_pll(current_source_field_r) &&
                  ((div_changed_w && !rc_changed_w) ||
                   (rc_changed_w && current_source_field_r == `SRC_RC_PLL) ||
                   (div_changed_w && current_source_field_r == `SRC_PRI_PLL));
  wire need_ost_w = primary_is_crystal && is_primary(dest_w) &&
                    !is_primary(current_source_field_r);
  wire sw_set_w = osc_ctrl_low_we && osc_ctrl_low_wdata[`OSC_SWITCH_REQUEST_BIT_BIT] && !busy_w;
  wire lock_done_w = (state_r == ST_LOCK) && (lock_cnt_r == 20'h00001);
  wire [19:0] lock_load_w = 20'(LOCK_CYCLES);

  // Divider fields are live to the loop as soon as written.
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      input_prescale_field_r <= `PRE_RST;
      output_postscale_field_r <= `POST_RST;
      rc_postscale_field_r <= `RCDIV_RST;
      feedback_ratio_field_r <= `FBD_RST;
    end else begin
      if (clock_divisor_register_we) begin
        input_prescale_field_r <= clock_divisor_register_wdata[`PRE_MSB:`PRE_LSB];
        output_postscale_field_r <= clock_divisor_register_wdata[`POST_MSB:`POST_LSB];
        rc_postscale_field_r <= clock_divisor_register_wdata[`RCDIV_MSB:`RCDIV_LSB];
      end
      if (feedback_divisor_register_we) begin
        feedback_ratio_field_r <= feedback_divisor_register_wdata[`FBD_MSB:`FBD_LSB];
      end
    end
  end

  // The requested source is write-protected while a switch is running.
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      requested_source_field_r <= `SRC_RC;
    end else if (state_r == ST_BOOT) begin
      requested_source_field_r <= reset_source_select;
    end else if (osc_ctrl_high_we && !busy_w) begin
      requested_source_field_r <= osc_ctrl_high_wdata[2:0];
    end
  end

  // Source switching and lock sequencing.
  always_comb begin
    state_nxt = state_r;
    current_source_field_nxt = current_source_field_r;
    switch_request_bit_nxt = switch_request_bit_r;
    lock_nxt = lock_r;
    lock_cnt_nxt = lock_cnt_r;
    ost_start = 1'b0;
    case (state_r)
      ST_BOOT: begin
        current_source_field_nxt = reset_source_select;
        lock_nxt = 1'b0;
        if (uses_pll(reset_source_select)) begin
          if (primary_is_crystal && is_primary(reset_source_select)) begin
            ost_start = 1'b1;
            state_nxt = ST_WAIT_OSC;
          end else begin
            lock_cnt_nxt = lock_load_w;
            state_nxt = ST_LOCK;
          end
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAIT_OSC: begin
        if (ost_done) begin
          if (uses_pll(dest_w)) begin
            lock_cnt_nxt = lock_load_w;
            state_nxt = ST_LOCK;
          end else begin
            current_source_field_nxt = dest_w;
            switch_request_bit_nxt = 1'b0;
            lock_nxt = 1'b0;
            state_nxt = ST_RUN;
          end
        end
      end
      ST_LOCK: begin
        lock_cnt_nxt = 20'(lock_cnt_r - 20'h00001);
        if (lock_done_w) begin
          lock_nxt = 1'b1;
          if (switch_request_bit_r) begin
            current_source_field_nxt = dest_w;
            switch_request_bit_nxt = 1'b0;
          end
          state_nxt = ST_RUN;
        end
      end
      default: begin
        if (switch_request_bit_r) begin
          if (uses_pll(dest_w)) begin
            lock_nxt = 1'b0;
          end
          if (need_ost_w) begin
            ost_start = 1'b1;
            state_nxt = ST_WAIT_OSC;
          end else if (uses_pll(dest_w)) begin
            lock_cnt_nxt = lock_load_w;
            state_nxt = ST_LOCK;
          end else begin
            current_source_field_nxt = dest_w;
            switch_request_bit_nxt = 1'b0;
            lock_nxt = 1'b0;
          end
        end else if (relock_w) begin
          lock_nxt = 1'b0;
          lock_cnt_nxt = lock_load_w;
          state_nxt = ST_LOCK;
        end
        if (sw_set_w) begin
          switch_request_bit_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_BOOT;
      current_source_field_r <= `SRC_RC;
      switch_request_bit_r <= 1'b0;
      lock_r <= 1'b0;
      lock_cnt_r <= 20'h00000;
      icyc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      current_source_field_r <= current_source_field_nxt;
      switch_request_bit_r <= switch_request_bit_nxt;
      lock_r <= lock_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      icyc_r <= !icyc_r;
    end
  end

  startup_counter u_ost (
    .clk(clk),
    .rst_n(rst_sync_r),
    .start(ost_start),
    .osc_cycle(primary_cycle),
    .done(ost_done)
  );

  rc_postscaler u_rcdiv (
    .clk(clk),
    .rst_n(rst_sync_r),
    .div_code(rc_postscale_field_r),
    .tick(rc_tick)
  );

  // Loop input selection and ratio outputs.
  wire [2:0] loop_src_w = busy_w ? dest_w : current_source_field_r;
  assign loop_in_from_primary = is_primary(loop_src_w);
  assign loop_in_tick = is_primary(loop_src_w) ? primary_cycle : rc_tick;
  assign loop_selected = uses_pll(current_source_field_r);
  assign prescale_ratio = 6'(input_prescale_field_r) + 6'h02;
  assign feedback_ratio = 10'(feedback_ratio_field_r) + 10'h002;
  assign postscale_ratio = 4'({output_postscale_field_r, 1'b0}) + 4'h2;
  assign sysclk_denominator = 9'(prescale_ratio) * 9'(postscale_ratio);
  assign rc_divisor = rc_div_ratio(rc_postscale_field_r);
  assign lock_status = lock_r;
  assign instr_clk_en = icyc_r;
  assign clock_divisor_register_rdata = {5'h00, rc_postscale_field_r,
                                         output_postscale_field_r, 1'b0, input_prescale_field_r};
  assign feedback_divisor_register_rdata = {7'h00, feedback_ratio_field_r};
  assign oscillator_control_register_rdata = {1'b0, current_source_field_r, 1'b0,
                                              requested_source_field_r, 2'h0, lock_r, 4'h0,
                                              switch_request_bit_r};

  // Checks on the divider fields and the sequencing.
  logic first_r;
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  chk_reset_values: assert property (@(posedge clk) disable iff (!rst_sync_r)
    first_r |-> (prescale_ratio == 6'h02 && postscale_ratio == 4'h4 && feedback_ratio == 10'd50))
    else $error("divider fields not at reset values");
  chk_prescale_ratio: assert property (@(posedge clk) disable iff (!rst_sync_r)
    clock_divisor_register_we |=> prescale_ratio == 6'($past(clock_divisor_register_wdata[4:0])) + 6'h02)
    else $error("prescale ratio wrong");
  chk_feedback_ratio: assert property (@(posedge clk) disable iff (!rst_sync_r)
    feedback_divisor_register_we |=> feedback_ratio == 10'($past(feedback_divisor_register_wdata[8:0])) + 10'h002)
    else $error("feedback ratio wrong");
  chk_postscale_ratio: assert property (@(posedge clk) disable iff (!rst_sync_r)
    clock_divisor_register_we |=> postscale_ratio == 4'({$past(clock_divisor_register_wdata[7:6]), 1'b0}) + 4'h2)
    else $error("postscale ratio wrong");
  chk_lock_nonloop: assert property (@(posedge clk) disable iff (!rst_sync_r)
    (state_r == ST_RUN && !uses_pll(current_source_field_r)) |-> !lock_r)
    else $error("lock set on non-loop source");
  chk_lock_interval: assert property (@(posedge clk) disable iff (!rst_sync_r)
    $rose(lock_r) |-> $past(state_r) == ST_LOCK && $past(lock_cnt_r) == 20'h00001)
    else $error("lock set before interval elapsed");
  chk_switch_clears: assert property (@(posedge clk) disable iff (!rst_sync_r)
    (state_r == ST_RUN && switch_request_bit_r && uses_pll(dest_w)) |=> !lock_r)
    else $error("lock not cleared on loop switch");
  chk_ost_first: assert property (@(posedge clk) disable iff (!rst_sync_r)
    (state_r == ST_WAIT_OSC && !ost_done) |=> state_r != ST_LOCK)
    else $error("lock interval began before start-up release");
  chk_instr_half: assert property (@(posedge clk) disable iff (!rst_sync_r)
    !first_r |-> instr_clk_en != $past(instr_clk_en))
    else $error("instruction clock not half rate");
  chk_lock_readonly: assert property (@(posedge clk) disable iff (!rst_sync_r)
    (state_r == ST_RUN && !switch_request_bit_r && !relock_w) |=> $stable(lock_r))
    else $error("lock flag changed without cause");
endmodule

/* tb/pll_divider_and_lock_control_tb.sv */
// Self-checking testbench of the loop divider and lock control block.
`timescale 1ns/10ps
module pll_divider_and_lock_control_tb;
  localparam int LOCK_N = 8;
  localparam int MAX_CYCLES = 20000;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reset_source_select = 3'h0;
  logic primary_is_crystal = 1'b0;
  logic primary_cycle = 1'b0;
  logic clock_divisor_register_we = 1'b0;
  logic [15:0] clock_divisor_register_wdata = 16'h0;
  logic feedback_divisor_register_we = 1'b0;
  logic [15:0] feedback_divisor_register_wdata = 16'h0;
  logic osc_ctrl_high_we = 1'b0;
  logic [7:0] osc_ctrl_high_wdata = 8'h0;
  logic osc_ctrl_low_we = 1'b0;
  logic [7:0] osc_ctrl_low_wdata = 8'h0;
  logic [15:0] clock_divisor_register_rdata;
  logic [15:0] feedback_divisor_register_rdata;
  logic [15:0] oscillator_control_register_rdata;
  logic [5:0] prescale_ratio;
  logic [9:0] feedback_ratio;
  logic [3:0] postscale_ratio;
  logic [8:0] sysclk_denominator;
  logic [8:0] rc_divisor;
  logic loop_in_from_primary;
  logic loop_in_tick;
  logic loop_selected;
  logic lock_status;
  logic instr_clk_en;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int pulses = 0;
  bit prim_en = 1'b0;

  pll_divider_and_lock_control #(.LOCK_CYCLES(LOCK_N)) i_dut (
    .clk(clk), .rstn(rstn),
    .reset_source_select(reset_source_select),
    .primary_is_crystal(primary_is_crystal),
    .primary_cycle(primary_cycle),
    .clock_divisor_register_we(clock_divisor_register_we),
    .clock_divisor_register_wdata(clock_divisor_register_wdata),
    .feedback_divisor_register_we(feedback_divisor_register_we),
    .feedback_divisor_register_wdata(feedback_divisor_register_wdata),
    .osc_ctrl_high_we(osc_ctrl_high_we), .osc_ctrl_high_wdata(osc_ctrl_high_wdata),
    .osc_ctrl_low_we(osc_ctrl_low_we), .osc_ctrl_low_wdata(osc_ctrl_low_wdata),
    .clock_divisor_register_rdata(clock_divisor_register_rdata),
    .feedback_divisor_register_rdata(feedback_divisor_register_rdata),
    .oscillator_control_register_rdata(oscillator_control_register_rdata),
    .prescale_ratio(prescale_ratio), .feedback_ratio(feedback_ratio),
    .postscale_ratio(postscale_ratio), .sysclk_denominator(sysclk_denominator),
    .rc_divisor(rc_divisor), .loop_in_from_primary(loop_in_from_primary),
    .loop_in_tick(loop_in_tick), .loop_selected(loop_selected),
    .lock_status(lock_status), .instr_clk_en(instr_clk_en)
  );

  always #2 clk = ~clk;

  // The primary oscillator pulses every second clock while enabled.
  always @(posedge clk) begin
    #1;
    primary_cycle <= prim_en && !primary_cycle;
  end

  always @(posedge clk) begin
    if (primary_cycle === 1'b1) begin
      pulses = pulses + 1;
    end
    cycles = cycles + 1;
    if (cycles >= MAX_CYCLES) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic wr_clock_divisor_register(input logic [15:0] d);
    clock_divisor_register_we = 1'b1;
    clock_divisor_register_wdata = d;
    step(1);
    clock_divisor_register_we = 1'b0;
  endtask

  task automatic wr_fb(input logic [15:0] d);
    feedback_divisor_register_we = 1'b1;
    feedback_divisor_register_wdata = d;
    step(1);
    feedback_divisor_register_we = 1'b0;
  endtask

  // Writes the requested source, then sets the switch request one cycle later.
  task automatic request(input logic [2:0] src);
    osc_ctrl_high_we = 1'b1;
    osc_ctrl_high_wdata = {5'h00, src};
    step(1);
    osc_ctrl_high_we = 1'b0;
    osc_ctrl_low_we = 1'b1;
    osc_ctrl_low_wdata = 8'h01;
    step(1);
    osc_ctrl_low_we = 1'b0;
  endtask

  task automatic wait_lock(input int lim, output int n);
    n = 0;
    while (lock_status !== 1'b1 && n < lim) begin
      step(1);
      n = n + 1;
    end
  endtask

  function automatic logic [15:0] exp_rc(input logic [2:0] c);
    return (c == 3'h7) ? 16'h0100 : (16'h0001 << c);
  endfunction

  // Compares read back and every ratio output against the written fields.
  task automatic check_fields(input logic [15:0] d, input logic [15:0] f);
    logic [15:0] pre;
    logic [15:0] post;
    pre = 16'(d[4:0]) + 16'h2;
    post = 16'h2 * (16'(d[7:6]) + 16'h1);
    check_val(clock_divisor_register_rdata, {5'h0, d[10:8], d[7:6], 1'b0, d[4:0]}, "clock_divisor_register");
    check_val(feedback_divisor_register_rdata, {7'h0, f[8:0]}, "fbdiv");
    check_val(16'(prescale_ratio), pre, "prescale");
    check_val(16'(postscale_ratio), post, "postscale");
    check_val(16'(feedback_ratio), 16'(f[8:0]) + 16'h2, "feedback");
    check_val(16'(sysclk_denominator), pre * post, "denominator");
    check_val(16'(rc_divisor), exp_rc(d[10:8]), "rc divisor");
  endtask

  logic [15:0] d;
  logic [15:0] f;
  logic t;
  int n;
  int p0;

  initial begin
    void'($urandom(32'hee80));
    step(16);
    rstn = 1'b1;
    step(6);
    check_fields(16'h0040, 16'h0030);
    check_val(oscillator_control_register_rdata, 16'h0000, "osc reset");
    t = instr_clk_en;
    step(1);
    check_bit(instr_clk_en, ~t, "instr half rate");
    // Here the dividers are reprogrammed while the system runs without the loop.
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 16'h07df : (i == 1) ? 16'h0000 : 16'($urandom);
      f = (i == 0) ? 16'h01ff : (i == 1) ? 16'h0000 : 16'($urandom);
      wr_clock_divisor_register(d);
      step(1);
      wr_fb(f);
      step(1);
      check_fields(d, f);
      check_bit(lock_status, 1'b0, "lock off loop");
    end
    // RC divided by four, prescale two and feedback 152 keep the loop in range.
    wr_clock_divisor_register(16'h0200);
    step(1);
    wr_fb(16'h0096);
    step(1);
    n = 0;
    repeat (64) begin
      if (loop_in_tick === 1'b1) n = n + 1;
      step(1);
    end
    check_bit(n >= 15 && n <= 17, 1'b1, "rc tick rate");
    check_bit(loop_in_from_primary, 1'b0, "rc feeds loop");
    request(3'h1);
    repeat (LOCK_N) begin
      check_bit(lock_status, 1'b0, "lock early");
      step(1);
    end
    check_bit(oscillator_control_register_rdata[0], 1'b1, "switch pending");
    wait_lock(40, n);
    check_bit(lock_status, 1'b1, "rc loop lock");
    check_val(oscillator_control_register_rdata, 16'h1120, "osc rc loop");
    check_bit(loop_selected, 1'b1, "loop selected");
    osc_ctrl_low_we = 1'b1;
    osc_ctrl_low_wdata = 8'h00;
    step(1);
    osc_ctrl_low_we = 1'b0;
    step(2);
    check_bit(lock_status, 1'b1, "lock read only");
    // A divider write on the loop still restarts the full lock interval.
    wr_fb(16'h0097);
    step(1);
    check_bit(lock_status, 1'b0, "relock clear");
    wait_lock(40, n);
    check_bit(lock_status === 1'b1 && n == LOCK_N - 1, 1'b1, "relock time");
    primary_is_crystal = 1'b1;
    prim_en = 1'b1;
    p0 = pulses;
    request(3'h3);
    step(2);
    check_bit(lock_status, 1'b0, "switch clears lock");
    check_val(16'(oscillator_control_register_rdata[14:12]), 16'h1, "current holds");
    wait_lock(4000, n);
    check_bit(lock_status, 1'b1, "primary loop lock");
    check_bit(pulses - p0 >= 1024, 1'b1, "start-up before lock");
    check_val(oscillator_control_register_rdata, 16'h3320, "osc pri loop");
    check_bit(loop_in_from_primary, 1'b1, "primary feeds loop");
    request(3'h0);
    step(3);
    check_bit(lock_status, 1'b0, "lock clear on rc");
    check_bit(loop_selected, 1'b0, "loop not selected");
    check_val(oscillator_control_register_rdata, 16'h0000, "osc rc");
    rstn = 1'b0;
    reset_source_select = 3'h1;
    prim_en = 1'b0;
    step(4);
    rstn = 1'b1;
    step(3);
    check_bit(lock_status, 1'b0, "lock after reset");
    wait_lock(40, n);
    check_bit(lock_status, 1'b1, "power-on loop lock");
    check_val(oscillator_control_register_rdata, 16'h1120, "strap source");
    final_report();
  end
endmodule
